/* design/sras_flags.sv */
`timescale 1ns/1ps
// Converter status byte; a set beats any clear in the same cycle except reset and soft reset, which win
module sras_flags (
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire logic                  soft_reset,
    input  wire sras_pkg::sras_events_s ev,
    input  wire logic                  clr_main_read,
    input  wire logic                  clr_aux_read,
    input  wire logic                  clr_mode,
    output logic [7:0]                 status
);

    logic set_main_rdy;
    logic set_aux_rdy;
    logic set_cal;
    logic set_main_err;
    logic set_aux_err;

    assign set_main_rdy = ev.main_store | ev.main_cal_done;
    assign set_aux_rdy  = ev.aux_store | ev.aux_cal_done;
    assign set_cal      = ev.main_cal_done | ev.aux_cal_done;
    assign set_main_err = ev.main_clamp | ev.main_cal_fail
                        | (ev.main_store & status[sras_pkg::SR_MISSING_REF]);
    assign set_aux_err  = ev.aux_clamp | ev.aux_cal_fail;

    always_ff @(posedge clk) begin
        if (!reset_n || soft_reset) begin
            status <= sras_pkg::STATUS_RESET;
        end else begin
            if (set_main_rdy) begin
                status[sras_pkg::SR_MAIN_READY] <= 1'b1;
            end else if (clr_main_read || ev.main_pre_update || clr_mode) begin
                status[sras_pkg::SR_MAIN_READY] <= 1'b0;
            end
            if (set_aux_rdy) begin
                status[sras_pkg::SR_AUX_READY] <= 1'b1;
            end else if (clr_aux_read || ev.aux_pre_update || clr_mode) begin
                status[sras_pkg::SR_AUX_READY] <= 1'b0;
            end
            if (set_cal) begin
                status[sras_pkg::SR_CAL_DONE] <= 1'b1;
            end else if (clr_mode) begin
                status[sras_pkg::SR_CAL_DONE] <= 1'b0;
            end
            if (ev.main_active) begin
                status[sras_pkg::SR_MISSING_REF] <= ev.ref_missing;
            end
            if (set_main_err) begin
                status[sras_pkg::SR_MAIN_ERROR] <= 1'b1;
            end else if (clr_mode) begin
                status[sras_pkg::SR_MAIN_ERROR] <= 1'b0;
            end
            if (set_aux_err) begin
                status[sras_pkg::SR_AUX_ERROR] <= 1'b1;
            end else if (clr_mode) begin
                status[sras_pkg::SR_AUX_ERROR] <= 1'b0;
            end
            status[sras_pkg::SR_RESERVED] <= 1'b0;
            status[sras_pkg::SR_PLL_LOCK] <= ev.pll_locked;
        end
    end

endmodule : sras_flags

/* design/sras_pkg.sv */
package sras_pkg;

    localparam int          DATA_W           = 24;
    localparam logic [4:0]  W_BYTE           = 5'h08;
    localparam logic [4:0]  W_WORD           = 5'h10;
    localparam logic [4:0]  W_LONG           = 5'h18;
    localparam logic [4:0]  W_NONE           = 5'h00;
    localparam int          CMD_DIR_BIT      = 6;
    localparam logic [5:0]  ONES_RESET_COUNT = 6'h20;
    localparam logic [2:0]  MODE_START_MIN   = 3'h2;
    localparam logic [7:0]  STATUS_RESET     = 8'h00;

    localparam logic [3:0]  ADDR_COMM_STATUS = 4'h0;
    localparam logic [3:0]  ADDR_MODE        = 4'h1;
    localparam logic [3:0]  ADDR_MAIN_CTRL   = 4'h2;
    localparam logic [3:0]  ADDR_AUX_CTRL    = 4'h3;
    localparam logic [3:0]  ADDR_FILTER      = 4'h4;
    localparam logic [3:0]  ADDR_MAIN_DATA   = 4'h5;
    localparam logic [3:0]  ADDR_AUX_DATA    = 4'h6;
    localparam logic [3:0]  ADDR_IO_CTRL     = 4'h7;
    localparam logic [3:0]  ADDR_MAIN_OFFSET = 4'h8;
    localparam logic [3:0]  ADDR_AUX_OFFSET  = 4'h9;
    localparam logic [3:0]  ADDR_MAIN_GAIN   = 4'ha;
    localparam logic [3:0]  ADDR_AUX_GAIN    = 4'hb;
    localparam logic [3:0]  ADDR_TEST1       = 4'hc;
    localparam logic [3:0]  ADDR_TEST2       = 4'hd;
    localparam logic [3:0]  ADDR_UNDEFINED   = 4'he;
    localparam logic [3:0]  ADDR_IDENT       = 4'hf;

    localparam int          SR_MAIN_READY    = 7;
    localparam int          SR_AUX_READY     = 6;
    localparam int          SR_CAL_DONE      = 5;
    localparam int          SR_MISSING_REF   = 4;
    localparam int          SR_MAIN_ERROR    = 3;
    localparam int          SR_AUX_ERROR     = 2;
    localparam int          SR_RESERVED      = 1;
    localparam int          SR_PLL_LOCK      = 0;

    typedef enum logic [1:0] {ST_COMMAND, ST_WRITE, ST_READ} sras_state_e;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic din;
    } sras_pins_s;

    typedef struct packed {
        logic main_store;
        logic aux_store;
        logic main_cal_done;
        logic aux_cal_done;
        logic main_clamp;
        logic aux_clamp;
        logic main_cal_fail;
        logic aux_cal_fail;
        logic main_pre_update;
        logic aux_pre_update;
        logic main_active;
        logic ref_missing;
        logic pll_locked;
    } sras_events_s;

    // Data phase length per address and direction
    function automatic logic [4:0] sras_reg_width(input logic [3:0] addr,
                                                  input logic       is_read,
                                                  input logic       main_long);
        logic [4:0] w;
        w = W_BYTE;
        if (addr == ADDR_COMM_STATUS) begin
            w = is_read ? W_BYTE : W_NONE;
        end else if (addr == ADDR_MAIN_DATA) begin
            w = main_long ? W_LONG : W_WORD;
        end else if (addr == ADDR_AUX_DATA || addr == ADDR_IO_CTRL ||
                     addr == ADDR_AUX_OFFSET || addr == ADDR_AUX_GAIN ||
                     addr == ADDR_TEST1 || addr == ADDR_TEST2) begin
            w = W_WORD;
        end else if (addr == ADDR_MAIN_OFFSET || addr == ADDR_MAIN_GAIN) begin
            w = W_LONG;
        end
        return w;
    endfunction : sras_reg_width

endpackage : sras_pkg

/* design/sras_sync.sv */
`timescale 1ns/1ps
// Three-stage pin synchroniser; output moves when stages two and three agree
module sras_sync #(
    parameter int W = 3
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s1 <= '1;
            s2 <= '1;
            s3 <= '1;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q <= '1;
        end else begin
            q <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & q);
        end
    end

endmodule : sras_sync

/* design/sras_top.sv */
`timescale 1ns/1ps
module sras_top (
    // System
    input  wire logic                   CLK,
    input  wire logic                   RESET_N,
    // Serial pins
    input  wire logic                   CS_N,
    input  wire logic                   SCLK,
    input  wire logic                   DIN,
    output logic                        DOUT,
    output logic                        DOUT_OE_N,
    // Register side towards the rest of the device
    input  wire logic                   MAIN_DATA_LONG,
    output logic                        REG_WR,
    output logic                        REG_RD,
    output logic [3:0]                  REG_ADDR,
    output logic [sras_pkg::DATA_W-1:0] REG_WDATA,
    input  wire logic [sras_pkg::DATA_W-1:0] REG_RDATA,
    output logic                        SOFT_RESET,
    // Converter events and status
    input  wire sras_pkg::sras_events_s EVENTS,
    output logic [7:0]                  STATUS
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam int DW = sras_pkg::DATA_W;

    sras_pkg::sras_pins_s  pins_raw;
    sras_pkg::sras_pins_s  pins;
    sras_pkg::sras_pins_s  pins_prev;
    sras_pkg::sras_state_e state;

    logic          sclk_rise;
    logic          sclk_fall;
    logic [4:0]    bit_cnt;
    logic [4:0]    data_len;
    logic [DW-1:0] shift_in;
    logic [DW-1:0] shift_out;
    logic [7:0]    command;
    logic [5:0]    ones_cnt;
    logic          load_pend;
    logic          clr_main_read;
    logic          clr_aux_read;
    logic          clr_mode;
    logic          soft_reset;
    logic          restart;

    logic [7:0]    next_command;
    logic          next_is_read;
    logic [3:0]    next_addr;
    logic [4:0]    next_len;
    logic [DW-1:0] next_word;
    logic          last_bit;

    // ------------------------------------------------------------
    // Pin synchronisation and clock edges
    // ------------------------------------------------------------
    assign pins_raw.cs_n = CS_N;
    assign pins_raw.sclk = SCLK;
    assign pins_raw.din  = DIN;

    sras_sync #(
        .W($bits(sras_pkg::sras_pins_s))
    ) u_sync (
        .clk     (CLK),
        .reset_n (RESET_N),
        .d       (pins_raw),
        .q       (pins)
    );

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            pins_prev <= '1;
        end else begin
            pins_prev <= pins;
        end
    end

    // Edges only count while the device is selected
    assign sclk_rise = !pins.cs_n && pins.sclk && !pins_prev.sclk;
    assign sclk_fall = !pins.cs_n && !pins.sclk && pins_prev.sclk;

    // ------------------------------------------------------------
    // Ones-sequence reset
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            ones_cnt <= 6'h00;
        end else if (sclk_rise) begin
            if (!pins.din) begin
                ones_cnt <= 6'h00;
            end else if (ones_cnt != sras_pkg::ONES_RESET_COUNT) begin
                ones_cnt <= ones_cnt + 6'h01;
            end
        end
    end

    // Fires once on the 32nd high bit, then waits for a low bit
    assign soft_reset = sclk_rise && pins.din &&
                        (ones_cnt == sras_pkg::ONES_RESET_COUNT - 6'h01);

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            SOFT_RESET <= 1'b0;
        end else begin
            SOFT_RESET <= soft_reset;
        end
    end

    assign restart = !RESET_N || soft_reset;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    // Gate bit is zero once the byte completes; six bits held, one arriving
    assign next_command = {1'b0, shift_in[5:0], pins.din};
    assign next_is_read = next_command[sras_pkg::CMD_DIR_BIT];
    assign next_addr    = next_command[3:0];
    assign next_len     = sras_pkg::sras_reg_width(next_addr, next_is_read,
                                                   MAIN_DATA_LONG);
    assign next_word    = {shift_in[DW-2:0], pins.din};
    assign last_bit     = (bit_cnt == data_len - 5'h01);

    // ------------------------------------------------------------
    // Interface sequence
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (restart) begin
            state <= sras_pkg::ST_COMMAND;
        end else if (sclk_rise) begin
            case (state)
                sras_pkg::ST_COMMAND: begin
                    if (bit_cnt == 5'h07) begin
                        if (next_len == sras_pkg::W_NONE) begin
                            state <= sras_pkg::ST_COMMAND;
                        end else if (next_is_read) begin
                            state <= sras_pkg::ST_READ;
                        end else begin
                            state <= sras_pkg::ST_WRITE;
                        end
                    end
                end
                sras_pkg::ST_WRITE: begin
                    if (last_bit) begin
                        state <= sras_pkg::ST_COMMAND;
                    end
                end
                sras_pkg::ST_READ: begin
                    if (last_bit) begin
                        state <= sras_pkg::ST_COMMAND;
                    end
                end
                default: begin
                    state <= sras_pkg::ST_COMMAND;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Bit counter
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (restart) begin
            bit_cnt <= 5'h00;
        end else if (sclk_rise) begin
            case (state)
                sras_pkg::ST_COMMAND: begin
                    if (bit_cnt == 5'h00) begin
                        // A high gate bit is dropped in place
                        if (!pins.din) begin
                            bit_cnt <= 5'h01;
                        end
                    end else if (bit_cnt == 5'h07) begin
                        bit_cnt <= 5'h00;
                    end else begin
                        bit_cnt <= bit_cnt + 5'h01;
                    end
                end
                default: begin
                    if (last_bit) begin
                        bit_cnt <= 5'h00;
                    end else begin
                        bit_cnt <= bit_cnt + 5'h01;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Input shifter and command byte
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (restart) begin
            shift_in <= '0;
        end else if (sclk_rise) begin
            if (state == sras_pkg::ST_COMMAND && bit_cnt == 5'h07) begin
                shift_in <= '0;
            end else if (state != sras_pkg::ST_COMMAND || bit_cnt != 5'h00) begin
                shift_in <= next_word;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (restart) begin
            command  <= 8'h00;
            data_len <= sras_pkg::W_BYTE;
        end else if (sclk_rise && state == sras_pkg::ST_COMMAND
                     && bit_cnt == 5'h07) begin
            command  <= next_command;
            data_len <= next_len;
        end
    end

    // ------------------------------------------------------------
    // Register side strobes
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (restart) begin
            REG_ADDR <= 4'h0;
        end else if (sclk_rise && state == sras_pkg::ST_COMMAND
                     && bit_cnt == 5'h07) begin
            REG_ADDR <= next_addr;
        end
    end

    always_ff @(posedge CLK) begin
        if (restart) begin
            REG_RD    <= 1'b0;
            load_pend <= 1'b0;
        end else begin
            REG_RD    <= sclk_rise && state == sras_pkg::ST_COMMAND
                         && bit_cnt == 5'h07 && next_is_read;
            load_pend <= REG_RD;
        end
    end

    always_ff @(posedge CLK) begin
        if (restart) begin
            REG_WR    <= 1'b0;
            REG_WDATA <= '0;
            clr_mode  <= 1'b0;
        end else begin
            REG_WR   <= 1'b0;
            clr_mode <= 1'b0;
            if (sclk_rise && state == sras_pkg::ST_WRITE && last_bit) begin
                REG_WDATA <= next_word;
                // Undefined address swallows the data silently
                if (command[3:0] != sras_pkg::ADDR_UNDEFINED) begin
                    REG_WR <= 1'b1;
                end
                if (command[3:0] == sras_pkg::ADDR_MODE &&
                    next_word[2:0] >= sras_pkg::MODE_START_MIN) begin
                    clr_mode <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Output shifter
    // ------------------------------------------------------------
    function automatic logic [DW-1:0] align_left(input logic [DW-1:0] value,
                                                 input logic [4:0]    width);
        logic [4:0] gap;
        gap = sras_pkg::W_LONG - width;
        return value << gap;
    endfunction : align_left

    always_ff @(posedge CLK) begin
        if (restart) begin
            shift_out <= '0;
        end else if (load_pend) begin
            if (REG_ADDR == sras_pkg::ADDR_COMM_STATUS) begin
                shift_out <= align_left({16'h0000, STATUS}, data_len);
            end else if (REG_ADDR == sras_pkg::ADDR_UNDEFINED) begin
                shift_out <= '0;
            end else begin
                shift_out <= align_left(REG_RDATA, data_len);
            end
        end else if (sclk_fall && state == sras_pkg::ST_READ) begin
            shift_out <= {shift_out[DW-2:0], 1'b0};
        end
    end

    always_ff @(posedge CLK) begin
        if (restart) begin
            DOUT <= 1'b0;
        end else if (sclk_fall && state == sras_pkg::ST_READ) begin
            DOUT <= shift_out[DW-1];
        end
    end

    assign DOUT_OE_N = (state != sras_pkg::ST_READ);

    // ------------------------------------------------------------
    // Read-completion clears
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (restart) begin
            clr_main_read <= 1'b0;
            clr_aux_read  <= 1'b0;
        end else begin
            clr_main_read <= sclk_rise && state == sras_pkg::ST_READ && last_bit
                             && command[3:0] == sras_pkg::ADDR_MAIN_DATA;
            clr_aux_read  <= sclk_rise && state == sras_pkg::ST_READ && last_bit
                             && command[3:0] == sras_pkg::ADDR_AUX_DATA;
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    sras_flags u_flags (
        .clk           (CLK),
        .reset_n       (RESET_N),
        .soft_reset    (soft_reset),
        .ev            (EVENTS),
        .clr_main_read (clr_main_read),
        .clr_aux_read  (clr_aux_read),
        .clr_mode      (clr_mode),
        .status        (STATUS)
    );

endmodule : sras_top

/* test/sras_host.sv */
`timescale 1ns/1ps
// Host on the four-wire link; clock idles high between frames
module sras_host (
    input  wire logic clk,
    input  wire logic dout,
    output logic      cs_n,
    output logic      sclk,
    output logic      din
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b1;
        din  = 1'b0;
    end
    // Command then data in one frame, 80 ns a bit
    task automatic frame(input int n, input logic [63:0] v, output logic [63:0] rv);
        rv = '0;
        cs_n <= 1'b0;
        repeat (8) @(posedge clk);
        for (int i = n - 1; i >= 0; i--) begin
            sclk <= 1'b0;
            din  <= v[i];
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
            rv[i] = dout;
        end
        repeat (8) @(posedge clk);
        cs_n <= 1'b1;
        din  <= ~din;
        // Deselect stays visible before any next frame
        repeat (8) @(posedge clk);
    endtask : frame
endmodule : sras_host

/* test/sras_monitor.sv */
`timescale 1ns/1ps
module sras_monitor (
    // System
    input wire logic                         CLK,
    input wire logic                         RESET_N,
    // Watched ports
    input wire logic                         DOUT_OE_N,
    input wire logic                         REG_WR,
    input wire logic                         REG_RD,
    input wire logic [3:0]                   REG_ADDR,
    input wire logic [sras_pkg::DATA_W-1:0]  REG_WDATA,
    input wire logic                         SOFT_RESET,
    input wire sras_pkg::sras_events_s       EVENTS,
    input wire logic [7:0]                   STATUS
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    sequence mode_start;
        REG_WR && REG_ADDR == 4'h1 && REG_WDATA[2:0] >= 3'h2;
    endsequence
    reset_idle_a: assert property (
        $rose(RESET_N) |-> STATUS == 8'h00 && DOUT_OE_N && !REG_WR && !REG_RD)
        else $error("outputs not idle after reset");
    status_zero_a: assert property (STATUS[1] == 1'b0)
        else $error("reserved status bit set");
    // Reset holds the byte at zero while low; soft reset zeroes it for one cycle
    pll_follow_a: assert property (
        RESET_N |=> SOFT_RESET || STATUS[0] == $past(EVENTS.pll_locked))
        else $error("lock flag does not follow pll");
    store_sets_a: assert property (EVENTS.main_store |=> STATUS[7])
        else $error("main ready not set");
    cal_sets_a: assert property (EVENTS.main_cal_done |=> STATUS[5] && STATUS[7])
        else $error("calibration flag not set with ready");
    mode_clear_a: assert property (mode_start |=> (STATUS & 8'hec) == 8'h00)
        else $error("starting mode write left flags set");
    undef_write_a: assert property (REG_WR |-> REG_ADDR != 4'he)
        else $error("write issued to undefined address");
    wdata_align_a: assert property (
        REG_WR && REG_ADDR inside {4'h1, 4'h2, 4'h3, 4'h4} |-> REG_WDATA[23:8] == 16'h0000)
        else $error("byte write carries upper bits");
    strobe_pulse_a: assert property ((REG_WR || REG_RD) |=> !REG_WR && !REG_RD)
        else $error("strobe longer than one cycle");
    soft_pulse_a: assert property (SOFT_RESET |=> !SOFT_RESET)
        else $error("soft reset longer than one cycle");
endmodule : sras_monitor

/* test/test_serial_register_access_status.sv */
`timescale 1ns/1ps
module test_serial_register_access_status;
    typedef struct {logic [7:0] c; int w; logic lng; logic [23:0] d; logic [23:0] x;} sras_row_s;
    logic CLK = 1'b0, RESET_N = 1'b0, MAIN_DATA_LONG = 1'b0;
    logic CS_N, SCLK, DIN, DOUT, DOUT_OE_N, REG_WR, REG_RD, SOFT_RESET;
    logic [3:0] REG_ADDR;
    logic [7:0] STATUS;
    logic [23:0] REG_WDATA, REG_RDATA = '0;
    sras_pkg::sras_events_s EVENTS = 13'h0001;
    int n_fail = 0, n_compared = 0, n_wr = 0, n_soft = 0, m;
    logic [63:0] rv;
    // Command bits 5 and 4 always zero
    sras_row_s rows [9] = '{'{8'h01, 8, 0, 24'h2, 0}, '{8'h02, 8, 0, 24'ha5, 0},
        '{8'h08, 24, 0, 24'h123456, 0}, '{8'h0c, 16, 0, 24'hbeef, 0},
        '{8'h45, 16, 0, 24'hc3a1, 24'hc3a1}, '{8'h45, 24, 1, 24'h5a5a5a, 24'h5a5a5a},
        '{8'h46, 16, 0, 24'h1234, 24'h1234}, '{8'h4e, 8, 0, 24'hff, 24'h0},
        '{8'h4f, 8, 0, 24'h3c, 24'h3c}};
    always #5 CLK = ~CLK;
    always @(posedge CLK) begin
        if (REG_WR === 1'b1) n_wr++;
        if (SOFT_RESET === 1'b1) n_soft++;
    end
    sras_top i_dut (.CLK, .RESET_N, .CS_N, .SCLK, .DIN, .DOUT, .DOUT_OE_N, .MAIN_DATA_LONG,
        .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA, .REG_RDATA, .SOFT_RESET, .EVENTS, .STATUS);
    sras_host i_host (.clk(CLK), .dout(DOUT), .cs_n(CS_N), .sclk(SCLK), .din(DIN));
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic finish_test;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    task automatic go(input int n, input logic [63:0] v);
        i_host.frame(n, v, rv);
    endtask : go
    task automatic pulse(input logic [12:0] e);
        EVENTS <= e;
        @(posedge CLK);
        EVENTS <= {10'h000, e[2:0]};
        @(posedge CLK);
    endtask : pulse
    initial begin
        repeat (10) @(posedge CLK);
        RESET_N <= 1'b1;
        repeat (4) @(posedge CLK);
        foreach (rows[k]) begin
            REG_RDATA <= rows[k].d;
            MAIN_DATA_LONG <= rows[k].lng;
            m = n_wr;
            go(8 + rows[k].w, (64'(rows[k].c) << rows[k].w) | 64'(rows[k].d));
            chk(24'(REG_ADDR), 24'(rows[k].c[3:0]));
            if (rows[k].c[6]) begin
                chk(24'(rv & ((64'h1 << rows[k].w) - 1)), rows[k].x);
            end else begin
                chk(REG_WDATA, rows[k].d);
            end
            chk(24'(n_wr - m), 24'(!rows[k].c[6]));
            $display("row %0d done", k);
        end
        // ----------------------------------------
        // Awkward cases
        // ----------------------------------------
        // Both ready flags, calibration, both errors, lock, then missing reference
        pulse(13'h1d81);
        EVENTS <= 13'h0007;
        go(16, 64'h4000);
        chk(24'(rv[7:4]), 24'hf);
        chk(24'(rv[3:0]), 24'hd);
        EVENTS <= 13'h0005;
        go(16, 64'h0103);
        go(16, 64'h4000);
        chk(24'(rv[7:0]), 24'h01);
        m = n_wr;
        go(43, {3'b111, 8'h00, 8'h0e, 8'hff, 8'h40, 8'h00});
        chk(24'(rv[7:0]), 24'h01);
        chk(24'(n_wr - m), 24'h0);
        $display("status and sequence tests done");
        // Main data read drops main ready only
        pulse(13'h1805);
        go(24, 64'h450000);
        go(16, 64'h4000);
        chk(24'(rv[7:0]), 24'h41);
        pulse(13'h1005);
        m = n_soft;
        go(48, {8'h0c, 40'hff_ffff_ffff});
        go(16, 64'h4000);
        chk(24'(rv[7:0]), 24'h01);
        chk(24'(n_soft - m), 24'h1);
        pulse(13'h1001);
        RESET_N <= 1'b0;
        repeat (4) @(posedge CLK);
        chk(24'(STATUS), 24'h00);
        RESET_N <= 1'b1;
        repeat (4) @(posedge CLK);
        go(16, 64'h4000);
        chk(24'(rv[7:0]), 24'h01);
        $display("reset tests done");
        finish_test();
    end
endmodule : test_serial_register_access_status
bind sras_top sras_monitor i_mon (.CLK, .RESET_N, .DOUT_OE_N, .REG_WR, .REG_RD, .REG_ADDR,
    .REG_WDATA, .SOFT_RESET, .EVENTS, .STATUS);
